// File: ict_timing.v
`timescale 1ns/1ps
`default_nettype none
`include "ict_defs.vh"
// Summary of operation
// - each instruction costs a triple of clocks, reads and writes, next fetch included.
// - memory forms outside loop mode add the address-calculation clocks, reads and writes to the base.
// - complement, complement-with-extend and invert cost 4(1/0), 6 long, memory 8(1/1) or 12(1/2).
// - decimal negate 6(1/0) register, test-and-set memory 14(2/1), compare-to-zero memory 4(1/0).
// - zero-fill register 4(1/0) or 6 long, memory indirect 8(1/1) or 12(1/2).
// - zero-fill through the indexed form costs the same for word or long index.
// - write-only memory forms are charged the non-fetching address time.
// - loop zero-fill costs 10(0/1) continued, 18(2/1) condition-true, 16(2/1) expired, or 14(0/2), 22(2/2), 20(2/2) long.
// - register shifts cost 6+2n(1/0), or 8+2n(1/0) for long.
// - memory shifts are word only, one position, 8(1/1) plus address time.
// - loop memory shifts cost 18(1/1), 24(3/1) and 22(3/1), each 2 more with pre-decrement.
// - byte memory bit zero costs 10(1/1) or 14(2/1), bit probe 4(1/0) or 8(2/0).
module ict_timing #(
    parameter CLK_W = `ICT_CLK_W,
    parameter BUS_W = `ICT_BUS_W
) (
    input  wire                 mclk,
    input  wire                 rst_b,
    input  wire                 start,
    input  wire [`ICT_OP_W-1:0] opcode,
    input  wire [`ICT_EA_W-1:0] ea_mode,
    input  wire                 is_long,
    input  wire                 bit_static,
    input  wire [5:0]           shift_count,
    input  wire                 loop_mode,
    input  wire [1:0]           loop_exit,
    output wire                 busy,
    output reg                  done_r,
    output reg  [CLK_W-1:0]     clk_total_r,
    output reg  [BUS_W-1:0]     rd_total_r,
    output reg  [BUS_W-1:0]     wr_total_r
);
    localparam ST_IDLE = 1'b0;
    localparam ST_RUN  = 1'b1;

    reg             state_r;
    reg [CLK_W-1:0] remain_r;
    reg [CLK_W-1:0] base_clk;
    reg [BUS_W-1:0] base_rd;
    reg [BUS_W-1:0] base_wr;
    reg             add_ea;
    reg             nonfetch;
    wire            is_mem = (ea_mode != `ICT_EA_DREG);
    wire [`ICT_CLK_W-1:0] ea_clk;
    wire [`ICT_BUS_W-1:0] ea_rd;
    wire [`ICT_BUS_W-1:0] ea_wr;

    ict_ea_cost u_ea (
        .ea_mode  (ea_mode),
        .is_long  (is_long),
        .nonfetch (nonfetch),
        .ea_clk   (ea_clk),
        .ea_rd    (ea_rd),
        .ea_wr    (ea_wr)
    );

    // ==========================================
    // base cost table
    always @* begin
        base_clk = 8'h04;
        base_rd  = 4'h1;
        base_wr  = 4'h0;
        add_ea   = is_mem;
        nonfetch = 1'b0;
        case (opcode)
            `ICT_OP_NEG, `ICT_OP_COMPLEMENT_WITH_EXTEND, `ICT_OP_NOT: begin
                if (loop_mode) begin
                    add_ea = 1'b0;
                    base_rd = is_long ? 4'h2 : 4'h1;
                    base_wr = is_long ? 4'h2 : 4'h1;
                    base_clk = is_long ? 8'h18 : 8'h10;
                    if (loop_exit == `ICT_LP_CCTRUE) begin
                        base_clk = base_clk + 8'h06;
                        base_rd = base_rd + 4'h2;
                    end else if (loop_exit == `ICT_LP_EXPIRED) begin
                        base_clk = base_clk + 8'h04;
                        base_rd = base_rd + 4'h2;
                    end
                end else if (is_mem) begin
                    base_clk = is_long ? 8'h0C : 8'h08;
                    base_wr  = is_long ? 4'h2 : 4'h1;
                end else begin
                    base_clk = is_long ? 8'h06 : 8'h04;
                end
            end
            `ICT_OP_DECIMAL_NEGATE_EXTEND: begin
                base_clk = is_mem ? 8'h08 : 8'h06;
                base_wr  = is_mem ? 4'h1 : 4'h0;
            end
            `ICT_OP_TAS: begin
                if (is_mem) begin
                    base_clk = 8'h0E;
                    base_rd  = 4'h2;
                    base_wr  = 4'h1;
                end
            end
            `ICT_OP_TST: begin
                base_clk = 8'h04;
            end
            `ICT_OP_CLR: begin
                add_ea = 1'b0;
                if (loop_mode) begin
                    base_rd  = 4'h0;
                    base_wr  = is_long ? 4'h2 : 4'h1;
                    base_clk = is_long ? 8'h0E : 8'h0A;
                    if (loop_exit == `ICT_LP_CCTRUE) begin
                        base_clk = base_clk + 8'h08;
                        base_rd  = 4'h2;
                    end else if (loop_exit == `ICT_LP_EXPIRED) begin
                        base_clk = base_clk + 8'h06;
                        base_rd  = 4'h2;
                    end
                end else if (is_mem) begin
                    add_ea   = 1'b1;
                    nonfetch = 1'b1;
                    base_clk = is_long ? 8'h0C : 8'h08;
                    base_wr  = is_long ? 4'h2 : 4'h1;
                end else begin
                    base_clk = is_long ? 8'h06 : 8'h04;
                end
            end
            `ICT_OP_SHIFT: begin
                if (loop_mode) begin
                    add_ea   = 1'b0;
                    base_wr  = 4'h1;
                    base_clk = 8'h12;
                    if (loop_exit == `ICT_LP_CCTRUE) begin
                        base_clk = 8'h18;
                        base_rd  = 4'h3;
                    end else if (loop_exit == `ICT_LP_EXPIRED) begin
                        base_clk = 8'h16;
                        base_rd  = 4'h3;
                    end
                end else if (is_mem) begin
                    base_clk = 8'h08;
                    base_wr  = 4'h1;
                end else begin
                    base_clk = (is_long ? 8'h08 : 8'h06) + {1'b0, shift_count, 1'b0};
                end
            end
            `ICT_OP_BIT_TOGGLE, `ICT_OP_BIT_ONE: begin
                base_clk = bit_static ? 8'h0C : 8'h08;
                base_rd  = bit_static ? 4'h2 : 4'h1;
                base_wr  = is_mem ? 4'h1 : 4'h0;
            end
            `ICT_OP_BIT_ZERO: begin
                base_clk = bit_static ? 8'h0E : 8'h0A;
                base_rd  = bit_static ? 4'h2 : 4'h1;
                base_wr  = is_mem ? 4'h1 : 4'h0;
            end
            `ICT_OP_BIT_PROBE: begin
                base_rd = bit_static ? 4'h2 : 4'h1;
                if (is_mem)
                    base_clk = bit_static ? 8'h08 : 8'h04;
                else
                    base_clk = bit_static ? 8'h0A : 8'h06;
            end
            default: begin
                base_clk = 8'h04;
            end
        endcase
        // pre-decrement adds two clocks in loop mode
        if (loop_mode && ea_mode == `ICT_EA_PREDEC)
            base_clk = base_clk + 8'h02;
    end

    // ==========================================
    // sequencer: holds busy for one clock less than the total clock count, done on the last
    assign busy = (state_r == ST_RUN);

    always @(posedge mclk) begin
        if (!rst_b) begin
            state_r     <= ST_IDLE;
            remain_r    <= `ICT_ZERO_CLK;
            done_r      <= 1'b0;
            clk_total_r <= {CLK_W{1'b0}};
            rd_total_r  <= {BUS_W{1'b0}};
            wr_total_r  <= {BUS_W{1'b0}};
        end else begin
            done_r <= 1'b0;
            case (state_r)
                ST_IDLE: begin
                    if (start) begin
                        state_r <= ST_RUN;
                        if (add_ea) begin
                            clk_total_r <= base_clk + ea_clk;
                            rd_total_r  <= base_rd + ea_rd;
                            wr_total_r  <= base_wr + ea_wr;
                            remain_r    <= base_clk + ea_clk - 8'h02;
                        end else begin
                            clk_total_r <= base_clk;
                            rd_total_r  <= base_rd;
                            wr_total_r  <= base_wr;
                            remain_r    <= base_clk - 8'h02;
                        end
                    end
                end
                ST_RUN: begin
                    if (remain_r == `ICT_ZERO_CLK) begin
                        state_r <= ST_IDLE;
                        done_r  <= 1'b1;
                    end else begin
                        remain_r <= remain_r - 8'h01;
                    end
                end
                default: state_r <= ST_IDLE;
            endcase
        end
    end
endmodule // ict_timing
`default_nettype wire

// File: ict_defs.vh
`ifndef ICT_DEFS_VH
`define ICT_DEFS_VH
// ==========================================
// opcode classes
`define ICT_OP_W          4
`define ICT_OP_NEG        4'h0
`define ICT_OP_COMPLEMENT_WITH_EXTEND       4'h1
`define ICT_OP_NOT        4'h2
`define ICT_OP_DECIMAL_NEGATE_EXTEND       4'h3
`define ICT_OP_TAS        4'h4
`define ICT_OP_TST        4'h5
`define ICT_OP_CLR        4'h6
`define ICT_OP_SHIFT      4'h7
`define ICT_OP_BIT_TOGGLE       4'h8
`define ICT_OP_BIT_ZERO       4'h9
`define ICT_OP_BIT_ONE       4'hA
`define ICT_OP_BIT_PROBE       4'hB
// ==========================================
// addressing forms
`define ICT_EA_W          3
`define ICT_EA_DREG       3'h0
`define ICT_EA_IND        3'h1
`define ICT_EA_POSTINC    3'h2
`define ICT_EA_PREDEC     3'h3
`define ICT_EA_DISP16     3'h4
`define ICT_EA_INDEX      3'h5
`define ICT_EA_ABSW       3'h6
`define ICT_EA_ABSL       3'h7
// ==========================================
// loop outcome
`define ICT_LP_CONT       2'h0
`define ICT_LP_CCTRUE     2'h1
`define ICT_LP_EXPIRED    2'h2
// ==========================================
// cost field widths
`define ICT_CLK_W         8
`define ICT_BUS_W         4
`define ICT_ZERO_CLK      8'h00
`define ICT_ZERO_BUS      4'h0
`endif

// File: ict_ea_cost.v
`timescale 1ns/1ps
`default_nettype none
`include "ict_defs.vh"
// ==========================================
// effective-address cost lookup
module ict_ea_cost (
    input  wire [`ICT_EA_W-1:0]  ea_mode,
    input  wire                  is_long,
    input  wire                  nonfetch,
    output reg  [`ICT_CLK_W-1:0] ea_clk,
    output reg  [`ICT_BUS_W-1:0] ea_rd,
    output reg  [`ICT_BUS_W-1:0] ea_wr
);
    // index width is not an input: it never changes the cost
    always @* begin
        ea_wr = `ICT_ZERO_BUS;
        case (ea_mode)
            `ICT_EA_IND: begin
                ea_clk = is_long ? 8'h08 : 8'h04;
                ea_rd  = is_long ? 4'h2 : 4'h1;
            end
            `ICT_EA_POSTINC: begin
                ea_clk = is_long ? 8'h08 : 8'h04;
                ea_rd  = is_long ? 4'h2 : 4'h1;
            end
            `ICT_EA_PREDEC: begin
                ea_clk = is_long ? 8'h0A : 8'h06;
                ea_rd  = is_long ? 4'h2 : 4'h1;
            end
            `ICT_EA_DISP16, `ICT_EA_ABSW: begin
                ea_clk = is_long ? 8'h0C : 8'h08;
                ea_rd  = is_long ? 4'h3 : 4'h2;
            end
            `ICT_EA_INDEX: begin
                ea_clk = is_long ? 8'h0E : 8'h0A;
                ea_rd  = is_long ? 4'h3 : 4'h2;
            end
            `ICT_EA_ABSL: begin
                ea_clk = is_long ? 8'h10 : 8'h0C;
                ea_rd  = is_long ? 4'h4 : 4'h3;
            end
            default: begin
                ea_clk = `ICT_ZERO_CLK;
                ea_rd  = `ICT_ZERO_BUS;
            end
        endcase
        // write-only operands skip the operand read
        if (nonfetch && ea_mode != `ICT_EA_DREG) begin
            ea_clk = (ea_mode == `ICT_EA_PREDEC) ? 8'h02 :
                     (ea_mode == `ICT_EA_INDEX)  ? 8'h08 :
                     (ea_mode == `ICT_EA_ABSL)   ? 8'h08 :
                     (ea_mode == `ICT_EA_DISP16 || ea_mode == `ICT_EA_ABSW) ? 8'h04 :
                     `ICT_ZERO_CLK;
            ea_rd  = (ea_mode == `ICT_EA_ABSL) ? 4'h2 :
                     (ea_mode == `ICT_EA_DISP16 || ea_mode == `ICT_EA_ABSW ||
                      ea_mode == `ICT_EA_INDEX) ? 4'h1 : `ICT_ZERO_BUS;
        end
    end
endmodule // ict_ea_cost
`default_nettype wire

// File: ict_timing_props.sv
`timescale 1ns/1ps
`default_nettype none
`include "ict_defs.vh"
// ==========================================
// timing checker
module ict_timing_props #(
    parameter CLK_W = 8,
    parameter BUS_W = 4
) (
    input wire logic             mclk,
    input wire logic             rst_b,
    input wire logic             start,
    input wire logic [3:0]       opcode,
    input wire logic [2:0]       ea_mode,
    input wire logic             is_long,
    input wire logic             bit_static,
    input wire logic [5:0]       shift_count,
    input wire logic             loop_mode,
    input wire logic [1:0]       loop_exit,
    input wire logic             busy,
    input wire logic             done_r,
    input wire logic [CLK_W-1:0] clk_total_r,
    input wire logic [BUS_W-1:0] rd_total_r,
    input wire logic [BUS_W-1:0] wr_total_r
);
    logic [CLK_W-1:0] busy_cnt_r;
    always_ff @(posedge mclk) begin
        if (!rst_b || !busy) begin
            busy_cnt_r <= '0;
        end else begin
            busy_cnt_r <= busy_cnt_r + 1'b1;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    sequence s_take; start && !busy; endsequence
    sequence s_reg; ea_mode == `ICT_EA_DREG && !loop_mode; endsequence
    property p_take_busy; s_take |=> busy; endproperty
    a_take_busy: assert property (p_take_busy) else $error("start not taken");
    property p_busy_len; done_r |-> busy_cnt_r == clk_total_r - 1'b1; endproperty
    a_busy_len: assert property (p_busy_len) else $error("busy length off");
    property p_fell_done; $past(rst_b) && $fell(busy) |-> done_r; endproperty
    a_fell_done: assert property (p_fell_done) else $error("no done after busy");
    property p_done_pulse; done_r |-> !busy ##1 !done_r; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done not a pulse");
    property p_stable; busy |=> $stable({clk_total_r, rd_total_r, wr_total_r}); endproperty
    a_stable: assert property (p_stable) else $error("totals moved while busy");
    property p_bounded; s_take |-> ##[4:255] done_r; endproperty
    a_bounded: assert property (p_bounded) else $error("no completion");
    property p_neg;
        s_take ##0 (opcode == `ICT_OP_NEG && !is_long) ##0 s_reg
            |=> clk_total_r == 8'h04 && rd_total_r == 4'h1 && wr_total_r == 4'h0;
    endproperty
    a_neg: assert property (p_neg) else $error("complement cost off");
    property p_shift;
        s_take ##0 (opcode == `ICT_OP_SHIFT && !is_long) ##0 s_reg
            |=> clk_total_r == 8'h06 + {$past(shift_count), 1'b0};
    endproperty
    a_shift: assert property (p_shift) else $error("shift cost off");
    property p_loop_clr;
        s_take ##0 (opcode == `ICT_OP_CLR && loop_mode && !is_long
            && loop_exit == `ICT_LP_CONT && ea_mode == `ICT_EA_IND)
            |=> clk_total_r == 8'h0A && rd_total_r == 4'h0 && wr_total_r == 4'h1;
    endproperty
    a_loop_clr: assert property (p_loop_clr) else $error("loop zero fill cost off");
    property p_clr_index;
        s_take ##0 (opcode == `ICT_OP_CLR && ea_mode == `ICT_EA_INDEX && !loop_mode && !is_long)
            |=> clk_total_r == 8'h10 && rd_total_r == 4'h2 && wr_total_r == 4'h1;
    endproperty
    a_clr_index: assert property (p_clr_index) else $error("indexed zero fill cost off");
endmodule // ict_timing_props
bind ict_timing ict_timing_props #(.CLK_W(CLK_W), .BUS_W(BUS_W)) ict_timing_props_inst (
    .mclk(mclk), .rst_b(rst_b), .start(start), .opcode(opcode), .ea_mode(ea_mode),
    .is_long(is_long), .bit_static(bit_static), .shift_count(shift_count),
    .loop_mode(loop_mode), .loop_exit(loop_exit), .busy(busy), .done_r(done_r),
    .clk_total_r(clk_total_r), .rd_total_r(rd_total_r), .wr_total_r(wr_total_r));
`default_nettype wire

// File: ict_mem_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// memory side: tallies bus cycles served
module ict_mem_model (
    input  wire logic        mclk,
    input  wire logic        rst_b,
    input  wire logic        done_r,
    input  wire logic [3:0]  rd_total_r,
    input  wire logic [3:0]  wr_total_r,
    output var  logic [15:0] rd_served,
    output var  logic [15:0] wr_served
);
    always @(posedge mclk) begin
        if (!rst_b) begin
            rd_served <= 16'h0000;
            wr_served <= 16'h0000;
        end else if (done_r) begin
            rd_served <= rd_served + 16'(rd_total_r);
            wr_served <= wr_served + 16'(wr_total_r);
        end
    end
endmodule // ict_mem_model
`default_nettype wire

// File: ict_timing_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "ict_defs.vh"
module ict_timing_bench;
    logic        mclk = 1'b0;
    logic        rst_b = 1'b0;
    logic        start = 1'b0;
    logic [3:0]  opcode = 4'h0;
    logic [2:0]  ea_mode = 3'h0;
    logic        is_long = 1'b0;
    logic        bit_static = 1'b0;
    logic [5:0]  shift_count = 6'h00;
    logic        loop_mode = 1'b0;
    logic [1:0]  loop_exit = 2'h0;
    wire         busy;
    wire         done_r;
    wire  [7:0]  clk_total_r;
    wire  [3:0]  rd_total_r;
    wire  [3:0]  wr_total_r;
    wire  [15:0] rd_served;
    wire  [15:0] wr_served;
    int          failures = 0;
    int          checks = 0;
    logic [15:0] exp_rd = 16'h0000;
    logic [15:0] exp_wr = 16'h0000;
    always #25 mclk = ~mclk;
    ict_timing ict_timing_inst (.mclk(mclk), .rst_b(rst_b), .start(start), .opcode(opcode),
        .ea_mode(ea_mode), .is_long(is_long), .bit_static(bit_static),
        .shift_count(shift_count), .loop_mode(loop_mode), .loop_exit(loop_exit), .busy(busy),
        .done_r(done_r), .clk_total_r(clk_total_r), .rd_total_r(rd_total_r),
        .wr_total_r(wr_total_r));
    ict_mem_model ict_mem_model_inst (.mclk(mclk), .rst_b(rst_b), .done_r(done_r),
        .rd_total_r(rd_total_r), .wr_total_r(wr_total_r), .rd_served(rd_served),
        .wr_served(wr_served));
    // ==========================================
    // shared driver: poke keeps start up for the first busy clock, which must be ignored
    task automatic run_op(input int op, ea, lng, st, n, lm, lx, e_clk, e_rd, e_wr, poke);
        int cyc;
        opcode = 4'(op);
        ea_mode = 3'(ea);
        is_long = 1'(lng);
        bit_static = 1'(st);
        shift_count = 6'(n);
        loop_mode = 1'(lm);
        loop_exit = 2'(lx);
        start = 1'b1;
        @(posedge mclk);
        #1;
        cyc = 1;
        start = 1'(poke);
        if (poke != 0) opcode = `ICT_OP_BIT_ZERO;
        while (done_r !== 1'b1) begin
            if (cyc >= 300) begin
                failures++;
                $display("mismatch at %0t: no completion", $time);
                wrap_up();
            end
            @(posedge mclk);
            #1;
            cyc++;
            if (cyc == 2) start = 1'b0;
            if (done_r !== 1'b1 && busy !== 1'b1) begin
                failures++;
                $display("mismatch at %0t: busy dropped early", $time);
            end
        end
        checks++;
        if (cyc != e_clk || clk_total_r !== 8'(e_clk) || rd_total_r !== 4'(e_rd)
            || wr_total_r !== 4'(e_wr) || busy !== 1'b0) begin
            failures++;
            $display("mismatch at %0t: op %0d got %0d(%0d/%0d) in %0d cycles", $time, op,
                clk_total_r, rd_total_r, wr_total_r, cyc);
        end
        exp_rd = exp_rd + 16'(e_rd);
        exp_wr = exp_wr + 16'(e_wr);
    endtask
    task automatic wrap_up();
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // ==========================================
    // scenarios, run back to back
    task automatic t_complement();
        run_op(`ICT_OP_NEG, 0, 0, 0, 0, 0, 0, 4, 1, 0, 0);
        run_op(`ICT_OP_COMPLEMENT_WITH_EXTEND, 0, 1, 0, 0, 0, 0, 6, 1, 0, 0);
        run_op(`ICT_OP_NOT, 1, 0, 0, 0, 0, 0, 12, 2, 1, 0);
        run_op(`ICT_OP_NOT, 1, 1, 0, 0, 0, 0, 20, 3, 2, 0);
        $display("test complement done");
    endtask
    task automatic t_decimal_probe();
        run_op(`ICT_OP_DECIMAL_NEGATE_EXTEND, 0, 0, 0, 0, 0, 0, 6, 1, 0, 0);
        run_op(`ICT_OP_TST, 7, 0, 0, 0, 0, 0, 16, 4, 0, 0);
        $display("test decimal and probe done");
    endtask
    task automatic t_refused();
        run_op(`ICT_OP_DECIMAL_NEGATE_EXTEND, 0, 0, 0, 0, 0, 0, 6, 1, 0, 1);
        $display("test refused start done");
    endtask
    task automatic t_zero_fill();
        run_op(`ICT_OP_CLR, 0, 0, 0, 0, 0, 0, 4, 1, 0, 0);
        run_op(`ICT_OP_CLR, 0, 1, 0, 0, 0, 0, 6, 1, 0, 0);
        run_op(`ICT_OP_CLR, 1, 0, 0, 0, 0, 0, 8, 1, 1, 0);
        run_op(`ICT_OP_CLR, 1, 1, 0, 0, 0, 0, 12, 1, 2, 0);
        run_op(`ICT_OP_CLR, 3, 0, 0, 0, 0, 0, 10, 1, 1, 0);
        run_op(`ICT_OP_CLR, 5, 0, 0, 0, 0, 0, 16, 2, 1, 0);
        run_op(`ICT_OP_CLR, 5, 1, 0, 0, 0, 0, 20, 2, 2, 0);
        $display("test zero fill done");
    endtask
    task automatic t_zero_loop();
        run_op(`ICT_OP_CLR, 1, 0, 0, 0, 1, 0, 10, 0, 1, 0);
        run_op(`ICT_OP_CLR, 1, 0, 0, 0, 1, 1, 18, 2, 1, 0);
        run_op(`ICT_OP_CLR, 2, 0, 0, 0, 1, 2, 16, 2, 1, 0);
        run_op(`ICT_OP_CLR, 3, 0, 0, 0, 1, 0, 12, 0, 1, 0);
        $display("test zero fill loop done");
    endtask
    task automatic t_shift();
        run_op(`ICT_OP_SHIFT, 0, 0, 0, 0, 0, 0, 6, 1, 0, 0);
        run_op(`ICT_OP_SHIFT, 0, 0, 0, 63, 0, 0, 132, 1, 0, 0);
        run_op(`ICT_OP_SHIFT, 0, 1, 0, 5, 0, 0, 18, 1, 0, 0);
        run_op(`ICT_OP_SHIFT, 1, 0, 0, 1, 0, 0, 12, 2, 1, 0);
        run_op(`ICT_OP_SHIFT, 1, 0, 0, 1, 1, 0, 18, 1, 1, 0);
        run_op(`ICT_OP_SHIFT, 2, 0, 0, 1, 1, 1, 24, 3, 1, 0);
        run_op(`ICT_OP_SHIFT, 1, 0, 0, 1, 1, 2, 22, 3, 1, 0);
        run_op(`ICT_OP_SHIFT, 3, 0, 0, 1, 1, 2, 24, 3, 1, 0);
        $display("test shift done");
    endtask
    task automatic t_bits();
        run_op(`ICT_OP_BIT_TOGGLE, 0, 1, 0, 0, 0, 0, 8, 1, 0, 0);
        run_op(`ICT_OP_BIT_ONE, 0, 1, 1, 0, 0, 0, 12, 2, 0, 0);
        run_op(`ICT_OP_BIT_ZERO, 0, 1, 0, 0, 0, 0, 10, 1, 0, 0);
        run_op(`ICT_OP_BIT_ZERO, 0, 1, 1, 0, 0, 0, 14, 2, 0, 0);
        run_op(`ICT_OP_BIT_ZERO, 2, 0, 0, 0, 0, 0, 14, 2, 1, 0);
        run_op(`ICT_OP_BIT_ZERO, 2, 0, 1, 0, 0, 0, 18, 3, 1, 0);
        run_op(`ICT_OP_BIT_PROBE, 1, 0, 0, 0, 0, 0, 8, 2, 0, 0);
        run_op(`ICT_OP_BIT_PROBE, 1, 0, 1, 0, 0, 0, 12, 3, 0, 0);
        run_op(`ICT_OP_BIT_PROBE, 0, 1, 1, 0, 0, 0, 10, 2, 0, 0);
        $display("test bit ops done");
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        #1;
        rst_b = 1'b1;
        t_complement();
        t_decimal_probe();
        t_refused();
        t_zero_fill();
        t_zero_loop();
        t_shift();
        t_bits();
        @(posedge mclk);
        #1;
        checks++;
        if (rd_served !== exp_rd || wr_served !== exp_wr) begin
            failures++;
            $display("mismatch at %0t: bus cycle tally", $time);
        end
        wrap_up();
    end
endmodule // ict_timing_bench
`default_nettype wire
